// ==== logic/seq_regs.svh ====
// Register offsets, memory map locations, field masks and timing constants
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH
// ----------------------------------------
// APB register map (byte addresses)
// ----------------------------------------
`define CFG_OFS 16'h0000
`define MASK_OFS 16'h0004
`define STAT_OFS 16'h0008
`define START_OFS 16'h000C
`define RAM_SEL_BIT 14
// ----------------------------------------
// Configuration and mask bits
// ----------------------------------------
`define CFG_RT 0
`define CFG_STOP 1
`define CFG_BUSY_N 2
`define CFG_AREA_B 3
`define CFG_TF 4
`define CFG_DBCA 5
`define CFG_SSF 6
`define CFG_SR 7
`define MSK_EOM 0
`define MSK_ERR 1
`define MSK_CTRL_MSG_DONE_IRQ 2
// ----------------------------------------
// Fixed shared RAM locations, descriptor offsets, steps and special values
// ----------------------------------------
`define RAM_WORDS 4096
`define SP_A 12'h100
`define CNT_A 12'h101
`define SP_B 12'h104
`define CNT_B 12'h105
`define LUT_A 12'h140
`define LUT_B 12'h1C0
`define DSE_TAG 8'h01
`define DSE_CMD 8'h02
`define DSE_BLK 8'h03
`define SP_STEP 8'h04
`define PTR_STEP 8'h01
`define CNT_DONE 8'hFF
`define TAG_NONE 16'hFFFF
`define BCAST_ADDR 5'h1F
// ----------------------------------------
// Block status masks and control word bits
// ----------------------------------------
`define BS_BEGIN 16'h8000
`define BS_DONE 16'h4000
`define BS_ERR 16'h1000
`define BS_TIMEOUT 16'h0200
`define BS_REJECT 16'h0100
`define CTL_BUS_A 7
`define CTL_BCAST 1
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define RESP_TIMEOUT_NS 14000
`define RESP_TIMEOUT_CYC ((`RESP_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== logic/seq_pkg.sv ====
// Types shared by the message sequencer and its bench
package seq_pkg;
  // Word delivered by the bus decoder
  typedef struct packed {
    logic [15:0] data;
    logic cmdSync;
    logic busA;
    logic err;
  } link_word_t;
  // Command word fields
  typedef struct packed {
    logic [4:0] addr;
    logic tr;
    logic [4:0] sa;
    logic [4:0] wc;
  } cmd_word_t;
  // Sequencer states, Gray coded along the declaration order
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_RD_SP = 4'h1, ST_WR_SOM = 4'h3, ST_WR_TAG = 4'h2,
    ST_WR_CMD = 4'h6, ST_RD_LUT = 4'h7, ST_RD_CTL = 4'h5, ST_RD_CMDW = 4'h4,
    ST_XFER = 4'hC, ST_END_IRQ = 4'hD, ST_RD_SP2 = 4'hF, ST_WR_EOM = 4'hE,
    ST_WR_TAG2 = 4'hA, ST_WR_SP = 4'hB, ST_RD_CNT = 4'h9, ST_WR_CNT = 4'h8
  } state_t;
endpackage

// ==== logic/msg_sequencer.sv ====
// Controller / terminal message sequencer with shared RAM and APB access
//
// Functional notes
// [R1] Controller start first reads the current-area stack pointer.
// [R2] Before a transfer write start flag into block status, then time tag.
// [R3] Read data block address from descriptor word four, then transfer.
// [R4] At message end pulse enabled done/error interrupt, re-read stack pointer.
// [R5] Rewrite block status: begin cleared, done and errors set; write time tag.
// [R6] Advance stack pointer by 4 and message count by 1.
// [R7] More messages pending pulses controller done interrupt if enabled.
// [R8] Stop-on-error halts further starts; pointer addresses next message.
// [R9] Pointers keep upper byte, lower byte wraps FF to 00.
// [R10] Terminal pointers at 0100/0104, tables at 0140 and 01C0.
// [R11] Table index is direction bit and subaddress; entry gives block pointer.
// [R12] Entries 0-31 receive commands, 32-63 transmit commands.
// [R13] Mode commands with data index the table like ordinary commands.
// [R14] Terminal transfer starts on valid command: start, words, end cycle.
// [R15] Start cycle: latch, read pointer, flag, tag, store command, read table.
// [R16] End cycle: interrupt, status update, time tag, pointer plus 4.
// [R17] Each enabled done or error event gives a low interrupt pulse; here a message with an error pulses only if MSK_ERR is set.
// [R18] Address match pin pulses low for valid command to own address.
// [R19] Mode command drives word count with latch 1; else subaddress, 0.
// [R20] Rejected command: error in status, no data sent, received data stored.
// [R21] Busy low: busy in status, receive data stored, no transmit data.
// [R22] Software keeps data blocks within one 256-word page.
// [R23] Four configuration bits set status word flags.
// [R24] Software loads message count in ones complement.
// [R25] Control word bus bit: 1 sends on bus A, 0 on bus B.
// [R26] Without a tag source the stored time tag is all ones.
// [R27] Reset clears configuration, mask and block status registers.
// [R28] List ends when the count rolls over; restart needs host start.
// [R29] Host and sequencer RAM accesses never collide in one cycle.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "seq_regs.svh"

module msg_sequencer import seq_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Words from the bus decoder
  input wire logic rxValid,
  input wire link_word_t rxWord,
  // Words to the bus encoder
  output logic txValid,
  output logic [15:0] txData,
  output logic txCmdSync,
  output logic txBusA,
  input wire logic txReady,
  // External time tag source
  input wire logic [15:0] tagData,
  input wire logic tagDrive,
  output logic tagEnable,
  // Terminal pins
  input wire logic [4:0] terminal_addr_in,
  input wire logic cmd_reject_n,
  output logic own_addr_match_n,
  output logic [4:0] cmd_field_out,
  output logic mode_cmd_latch,
  output logic bcast_received,
  output logic irq_n
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // [R9] Upper byte fixed, low byte wraps without carry
  function automatic logic [15:0] ptrAdd(input logic [15:0] p, input logic [7:0] n);
    ptrAdd = {p[15:8], p[7:0] + n};
  endfunction

  // Data words carried by a command; mode codes 16-31 carry one
  function automatic logic [5:0] wordsOf(input cmd_word_t c);
    if (c.sa == 5'h00 || c.sa == 5'h1F) begin
      wordsOf = {5'h00, c.wc[4]};
    end else if (c.wc == 5'h00) begin
      wordsOf = 6'h20;
    end else begin
      wordsOf = {1'b0, c.wc};
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] mem [0:`RAM_WORDS-1];
  state_t state;
  logic [7:0] cfg;
  logic [2:0] mask;
  logic running;
  logic startPulse;
  logic [15:0] blkStatus;
  logic [15:0] stackPtr;
  logic [15:0] msgCount;
  logic [15:0] blkPtr;
  logic [15:0] ctlWord;
  logic [15:0] hdrWord;
  cmd_word_t cmdWord;
  logic [5:0] txLeft;
  logic [5:0] rxLeft;
  logic rxFirst;
  logic hdrSent;
  logic errFlag;
  logic toFlag;
  logic rejFlag;
  logic [10:0] toCnt;
  logic irqPulse;
  logic matchPulse;
  logic ack;

  // ----------------------------------------
  // Decode wires
  // ----------------------------------------
  // [R10] fixed pointer and table spots
  wire logic [11:0] spAddr = cfg[`CFG_AREA_B] ? `SP_B : `SP_A;
  wire logic [11:0] cntAddr = cfg[`CFG_AREA_B] ? `CNT_B : `CNT_A;
  wire logic [11:0] lutBase = cfg[`CFG_AREA_B] ? `LUT_B : `LUT_A;
  wire logic rtMode = cfg[`CFG_RT];
  wire logic cmdHit = rxValid & rxWord.cmdSync & ~rxWord.err;
  wire cmd_word_t rxCmd = cmd_word_t'(rxWord.data);
  wire logic ownAddr = rxCmd.addr == terminal_addr_in;
  wire logic bcastAddr = rxCmd.addr == `BCAST_ADDR;
  wire logic rtStart = rtMode & cmdHit & (ownAddr | bcastAddr);
  wire logic bcGo = ~rtMode & running;
  wire logic isMode = rxCmd.sa == 5'h00 || rxCmd.sa == 5'h1F;
  // Word engine phases; terminal receive takes data before sending status
  wire logic txPhase = txLeft != 6'h00 && !(rxFirst && rxLeft != 6'h00);
  wire logic rxPhase = rxLeft != 6'h00 && !txPhase;
  wire logic xferRd = state == ST_XFER && txPhase && !txValid && hdrSent;
  wire logic xferWr = state == ST_XFER && rxPhase && rxValid;
  wire logic xferDone = txLeft == 6'h00 && rxLeft == 6'h00 && !txValid;
  wire logic timedOut = toCnt == 11'(`RESP_TIMEOUT_CYC);
  // Command fetched from the message block, and its word counts
  wire cmd_word_t newCmd;
  wire logic [15:0] memRd;
  assign newCmd = cmd_word_t'(memRd);
  wire logic [5:0] bcN = wordsOf(newCmd);
  wire logic [5:0] bcTx = newCmd.tr ? 6'h01 : 6'(bcN + 6'h01);
  wire logic [5:0] bcRx = 6'(newCmd.tr ? bcN : 6'h00) + {5'h00, ~ctlWord[`CTL_BCAST]};
  // Terminal answer lengths; rejection and busy suppress transmitted data
  wire logic rtBcast = cmdWord.addr == `BCAST_ADDR;
  wire logic rtRej = ~cmd_reject_n;
  wire logic rtBusy = ~cfg[`CFG_BUSY_N];
  wire logic [5:0] rtN = wordsOf(cmdWord);
  wire logic [5:0] rtData = (rtRej | rtBusy) ? 6'h00 : rtN;
  wire logic [5:0] rtTx = rtBcast ? 6'h00 : (cmdWord.tr ? 6'(rtData + 6'h01) : 6'h01);
  wire logic [5:0] rtRx = cmdWord.tr ? 6'h00 : rtN;
  wire logic [15:0] rtStatus = {terminal_addr_in, rtRej, 1'b0, cfg[`CFG_SR], 3'b000,
                                rtBcast, rtBusy, cfg[`CFG_SSF], cfg[`CFG_DBCA], cfg[`CFG_TF]};
  wire logic [15:0] eomStatus = (blkStatus & ~`BS_BEGIN) | `BS_DONE |
                                (errFlag ? `BS_ERR : 16'h0000) |
                                (toFlag ? `BS_TIMEOUT : 16'h0000) |
                                (rejFlag ? `BS_REJECT : 16'h0000);
  wire logic [15:0] nextCount = ptrAdd(memRd, `PTR_STEP);
  wire logic listEnd = nextCount[7:0] == `CNT_DONE;
  wire logic stopHere = errFlag & cfg[`CFG_STOP];
  wire logic [15:0] tagValue = tagDrive ? tagData : `TAG_NONE;
  // Descriptor word addresses
  wire logic [15:0] tagAt = ptrAdd(stackPtr, `DSE_TAG);
  wire logic [15:0] cmdAt = ptrAdd(stackPtr, `DSE_CMD);
  wire logic [15:0] blkAt = ptrAdd(stackPtr, `DSE_BLK);

  // ----------------------------------------
  // Sequencer RAM port
  // ----------------------------------------
  logic seqReq;
  logic seqWe;
  logic [11:0] seqAddr;
  logic [15:0] seqWdata;

  // At most one RAM access per state; pointer arithmetic keeps page wrap
  always_comb begin
    seqReq = 1'b1;
    seqWe = 1'b0;
    seqAddr = 12'h000;
    seqWdata = 16'h0000;
    tagEnable = 1'b0;
    case (state)
      // [R1] [R4] stack pointer fetch
      ST_RD_SP, ST_RD_SP2: seqAddr = spAddr;
      // [R2] start flag write
      ST_WR_SOM: begin
        seqWe = 1'b1;
        seqAddr = stackPtr[11:0];
        seqWdata = `BS_BEGIN;
      end
      // [R26] tag of ones when undriven
      ST_WR_TAG, ST_WR_TAG2: begin
        seqWe = 1'b1;
        seqAddr = tagAt[11:0];
        seqWdata = tagValue;
        tagEnable = 1'b1;
      end
      // [R15] command word store
      ST_WR_CMD: begin
        seqWe = 1'b1;
        seqAddr = cmdAt[11:0];
        seqWdata = cmdWord;
      end
      // [R3] [R11] [R12] [R13] block pointer lookup
      ST_RD_LUT: begin
        if (rtMode) begin
          seqAddr = lutBase | {6'h00, cmdWord.tr, cmdWord.sa};
        end else begin
          seqAddr = blkAt[11:0];
        end
      end
      ST_RD_CTL, ST_RD_CMDW: seqAddr = blkPtr[11:0];
      ST_XFER: begin
        seqReq = xferRd | xferWr;
        seqWe = xferWr;
        seqAddr = blkPtr[11:0];
        seqWdata = rxWord.data;
      end
      // [R5] [R16] closing status
      ST_WR_EOM: begin
        seqWe = 1'b1;
        seqAddr = stackPtr[11:0];
        seqWdata = eomStatus;
      end
      // [R6] [R16] stack pointer advance
      ST_WR_SP: begin
        seqWe = 1'b1;
        seqAddr = spAddr;
        seqWdata = ptrAdd(stackPtr, `SP_STEP);
      end
      ST_RD_CNT: seqAddr = cntAddr;
      // [R6] count advance
      ST_WR_CNT: begin
        seqWe = 1'b1;
        seqAddr = cntAddr;
        seqWdata = nextCount;
      end
      default: seqReq = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Shared RAM and APB slave
  // ----------------------------------------
  wire logic ramSel = paddr[`RAM_SEL_BIT];
  // [R29] sequencer owns the RAM in any cycle it asks; host waits
  wire logic grant = ~ramSel | ~seqReq;
  wire logic doAcc = psel & penable & ~ack & grant;
  wire logic hostRamWr = doAcc & pwrite & ramSel;
  wire logic [11:0] ramAddr = seqReq ? seqAddr : paddr[13:2];
  assign memRd = mem[ramAddr];
  wire logic hitCfg = ~ramSel && paddr == `CFG_OFS;
  wire logic hitMask = ~ramSel && paddr == `MASK_OFS;
  wire logic hitStat = ~ramSel && paddr == `STAT_OFS;
  wire logic hitStart = ~ramSel && paddr == `START_OFS;
  wire logic unmapped = ~(ramSel | hitCfg | hitMask | hitStat | hitStart);
  logic [31:0] readVal;

  // Read selection
  always_comb begin
    if (ramSel) begin
      readVal = {16'h0000, memRd};
    end else if (hitCfg) begin
      readVal = {24'h00_0000, cfg};
    end else if (hitMask) begin
      readVal = {29'h0000_0000, mask};
    end else if (hitStat) begin
      readVal = {msgCount[7:0], 3'b000, running, state, blkStatus};
    end else begin
      readVal = 32'h0000_0000;
    end
  end

  // Memory writes; the two writers are exclusive by the grant
  always_ff @(posedge clk) begin
    if (seqWe) begin
      mem[seqAddr] <= seqWdata;
    end else if (hostRamWr) begin
      mem[paddr[13:2]] <= pwdata[15:0];
    end
  end

  // Registered answer: pready one cycle after the access phase is granted
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ack <= doAcc;
      // Error flag stands only with its pready
      pslverr <= doAcc & unmapped;
      if (doAcc) begin
        prdata <= pwrite ? 32'h0000_0000 : readVal;
      end
    end
  end
  assign pready = ack;

  // Software registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // [R27] configuration and mask cleared
      cfg <= 8'h00;
      mask <= 3'b000;
      startPulse <= 1'b0;
    end else begin
      startPulse <= doAcc & pwrite & hitStart & pwdata[0];
      if (doAcc & pwrite & hitCfg) begin
        cfg <= pwdata[7:0];
      end
      if (doAcc & pwrite & hitMask) begin
        mask <= pwdata[2:0];
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      running <= 1'b0;
      blkStatus <= 16'h0000;
      stackPtr <= 16'h0000;
      msgCount <= 16'h0000;
      blkPtr <= 16'h0000;
      ctlWord <= 16'h0000;
      hdrWord <= 16'h0000;
      cmdWord <= 16'h0000;
      txLeft <= 6'h00;
      rxLeft <= 6'h00;
      rxFirst <= 1'b0;
      errFlag <= 1'b0;
      toFlag <= 1'b0;
      rejFlag <= 1'b0;
      txBusA <= 1'b0;
    end else begin
      if (startPulse) begin
        running <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          // [R14] terminal transfer starts on a valid command alone
          if (bcGo) begin
            state <= ST_RD_SP;
          end else if (rtStart) begin
            cmdWord <= rxCmd;
            txBusA <= rxWord.busA;
            state <= ST_RD_SP;
          end
        end
        ST_RD_SP: begin
          stackPtr <= memRd;
          state <= ST_WR_SOM;
        end
        ST_WR_SOM: begin
          blkStatus <= `BS_BEGIN;
          errFlag <= 1'b0;
          toFlag <= 1'b0;
          rejFlag <= 1'b0;
          state <= ST_WR_TAG;
        end
        // [R15] terminal stores its command before the lookup
        ST_WR_TAG: state <= rtMode ? ST_WR_CMD : ST_RD_LUT;
        ST_WR_CMD: state <= ST_RD_LUT;
        ST_RD_LUT: begin
          blkPtr <= memRd;
          if (rtMode) begin
            // [R20] [R21] [R23] status answer and data suppression
            rejFlag <= rtRej;
            hdrWord <= rtStatus;
            txLeft <= rtTx;
            rxLeft <= rtRx;
            rxFirst <= ~cmdWord.tr;
            state <= ST_XFER;
          end else begin
            state <= ST_RD_CTL;
          end
        end
        ST_RD_CTL: begin
          ctlWord <= memRd;
          blkPtr <= ptrAdd(blkPtr, `PTR_STEP);
          state <= ST_RD_CMDW;
        end
        ST_RD_CMDW: begin
          // [R25] bus chosen by the control word
          txBusA <= ctlWord[`CTL_BUS_A];
          cmdWord <= newCmd;
          hdrWord <= memRd;
          blkPtr <= ptrAdd(blkPtr, `PTR_STEP);
          txLeft <= bcTx;
          rxLeft <= bcRx;
          rxFirst <= 1'b0;
          state <= ST_XFER;
        end
        ST_XFER: begin
          if (xferRd || xferWr) begin
            blkPtr <= ptrAdd(blkPtr, `PTR_STEP);
          end
          if (txValid && txReady) begin
            txLeft <= 6'(txLeft - 6'h01);
          end
          // [R20] received words are stored even when rejected
          if (xferWr) begin
            rxLeft <= 6'(rxLeft - 6'h01);
            errFlag <= errFlag | rxWord.err;
          end else if (rxPhase && timedOut) begin
            rxLeft <= 6'h00;
            errFlag <= 1'b1;
            toFlag <= 1'b1;
          end
          if (xferDone) begin
            state <= ST_END_IRQ;
          end
        end
        ST_END_IRQ: state <= ST_RD_SP2;
        ST_RD_SP2: begin
          stackPtr <= memRd;
          state <= ST_WR_EOM;
        end
        ST_WR_EOM: begin
          blkStatus <= eomStatus;
          state <= ST_WR_TAG2;
        end
        ST_WR_TAG2: state <= ST_WR_SP;
        ST_WR_SP: begin
          stackPtr <= ptrAdd(stackPtr, `SP_STEP);
          state <= rtMode ? ST_IDLE : ST_RD_CNT;
        end
        ST_RD_CNT: begin
          msgCount <= memRd;
          state <= ST_WR_CNT;
        end
        ST_WR_CNT: begin
          msgCount <= nextCount;
          // [R8] [R28] list end or stop on error halts further starts
          if (listEnd || stopHere) begin
            running <= 1'b0;
            state <= ST_IDLE;
          end else begin
            state <= ST_RD_SP;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Encoder handshake; header word first, then data from the block
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txValid <= 1'b0;
      txData <= 16'h0000;
      txCmdSync <= 1'b0;
      hdrSent <= 1'b0;
      toCnt <= 11'h000;
    end else begin
      if (state != ST_XFER) begin
        hdrSent <= 1'b0;
      end
      if (txValid && txReady) begin
        txValid <= 1'b0;
      end else if (state == ST_XFER && txPhase && !txValid) begin
        txValid <= 1'b1;
        txData <= hdrSent ? memRd : hdrWord;
        txCmdSync <= ~hdrSent;
        hdrSent <= 1'b1;
      end
      // Response timer runs only while a word is awaited
      if (state == ST_XFER && rxPhase && !rxValid && !timedOut) begin
        toCnt <= 11'(toCnt + 11'h001);
      end else begin
        toCnt <= 11'h000;
      end
    end
  end

  // ----------------------------------------
  // Pins: interrupt, address match, command fields
  // ----------------------------------------
  // [R4] [R16] [R17] end or error pulse; [R7] controller done pulse
  wire logic endIrq = state == ST_END_IRQ &&
                      (errFlag ? mask[`MSK_ERR] : mask[`MSK_EOM]);
  wire logic moreIrq = state == ST_WR_CNT && !listEnd && !stopHere && mask[`MSK_CTRL_MSG_DONE_IRQ];
  // Status words from terminals also carry a sync; not counted as commands
  wire logic awaitStatus = state == ST_XFER && !rtMode;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqPulse <= 1'b0;
      matchPulse <= 1'b0;
      cmd_field_out <= 5'h00;
      mode_cmd_latch <= 1'b0;
      bcast_received <= 1'b0;
    end else begin
      irqPulse <= endIrq | moreIrq;
      // [R18] own address seen in either mode, except while the controller awaits a status in ST_XFER
      matchPulse <= cmdHit & ownAddr & ~awaitStatus;
      // [R19] field and latch for each accepted command
      if (state == ST_IDLE && rtStart) begin
        cmd_field_out <= isMode ? rxCmd.wc : rxCmd.sa;
        mode_cmd_latch <= isMode;
        bcast_received <= bcastAddr;
      end
    end
  end
  assign irq_n = ~irqPulse;
  assign own_addr_match_n = ~matchPulse;

endmodule

// ==== tb/bus_model.sv ====
// Stand-in for the bus encoder and decoder on the link side
`timescale 1ns/100ps
module bus_model import seq_pkg::*; (
  // Clock
  input wire logic clk,
  // Decoder side
  output logic rxValid,
  output link_word_t rxWord,
  // Encoder side
  input wire logic txValid,
  input wire logic [15:0] txData,
  input wire logic txCmdSync,
  input wire logic txBusA,
  output logic txReady
);
  logic [17:0] txq [$];
  initial begin
    rxValid = 1'b0;
    rxWord = '0;
    txReady = 1'b0;
  end
  // Accept after a random stall, like a busy encoder
  always @(posedge clk) begin
    txReady <= txValid && !txReady && ($urandom_range(0, 2) == 0);
    if (txValid === 1'b1 && txReady === 1'b1)
      txq.push_back({txBusA, txCmdSync, txData});
  end
  // Word gap first; idle data is scrambled so stale values never match
  task automatic sendWord(input logic [15:0] d, input logic sync);
    repeat (100) @(posedge clk);
    rxValid <= 1'b1;
    rxWord <= '{d, sync, 1'b1, 1'b0};
    @(posedge clk);
    rxValid <= 1'b0;
    rxWord.data <= ~d;
  endtask
endmodule

// ==== tb/msg_sequencer_sva.sv ====
// Port-level checks for the message sequencer
`timescale 1ns/100ps
module msg_sequencer_sva import seq_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxValid,
  input wire link_word_t rxWord,
  input wire logic txValid,
  input wire logic [15:0] txData,
  input wire logic txReady,
  input wire logic [4:0] terminal_addr_in,
  input wire logic own_addr_match_n,
  input wire logic irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_irq_pulse: assert property (!irq_n |=> irq_n)
    else $error("irq_n low too long");
  chk_match_pulse: assert property (!own_addr_match_n |=> own_addr_match_n)
    else $error("match pulse too long");
  chk_match_cause: assert property ($fell(own_addr_match_n) |-> $past(rxValid
    && rxWord.cmdSync && !rxWord.err && rxWord.data[15:11] == terminal_addr_in))
    else $error("match without own command");
  chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx word dropped");
  chk_tx_gap: assert property (txValid && txReady |=> !txValid)
    else $error("tx word too soon");
  chk_reset_idle: assert property ($fell(sys_rst) |-> irq_n && !txValid && !pready)
    else $error("outputs active after reset");
endmodule
bind msg_sequencer msg_sequencer_sva chk (.clk, .sys_rst, .pready, .pslverr, .rxValid,
  .rxWord, .txValid, .txData, .txReady, .terminal_addr_in, .own_addr_match_n, .irq_n);

// ==== tb/msg_sequencer_tb.sv ====
// Self-checking bench for the message sequencer
`timescale 1ns/100ps
`include "seq_regs.svh"
module msg_sequencer_tb import seq_pkg::*;;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, rxValid, txValid, txCmdSync;
  logic txBusA, txReady, tagDrive, tagEnable, cmd_reject_n, own_addr_match_n, err;
  logic mode_cmd_latch, bcast_received, irq_n;
  logic [15:0] paddr, txData, tagData, cmd;
  logic [15:0] dat [4];
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] terminal_addr_in, cmd_field_out, sa, wc;
  logic [3:0] f;
  logic [17:0] w;
  link_word_t rxWord;
  int num_errors, compares, cyc, irqs, hits, i0, h0, k, j;
  msg_sequencer uut (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .rxValid, .rxWord, .txValid, .txData, .txCmdSync, .txBusA, .txReady,
    .tagData, .tagDrive, .tagEnable, .terminal_addr_in, .cmd_reject_n, .own_addr_match_n,
    .cmd_field_out, .mode_cmd_latch, .bcast_received, .irq_n);
  bus_model bm (.clk, .rxValid, .rxWord, .txValid, .txData, .txCmdSync, .txBusA, .txReady);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse counters and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irqs <= irqs + (irq_n === 1'b0);
    hits <= hits + (own_addr_match_n === 1'b0);
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // APB master: request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [15:0] ram(input logic [11:0] i);
    return {2'b01, i, 2'b00};
  endfunction
  function automatic logic [15:0] status(input logic me, input logic bsy);
    return {terminal_addr_in, me, 1'b0, f[3], 4'h0, bsy, f[2:0]};
  endfunction
  task automatic rdChk(input string n, input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 0);
    cmp(n, e, rd);
  endtask
  task automatic waitIdle();
    while (bm.txq.size() == 0) @(posedge clk);
    do apb(1'b0, `STAT_OFS, 0); while (rd[20:16] !== 5'h0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, tagDrive, paddr, pwdata} = '0;
    cmd_reject_n = 1'b1;
    sys_rst = 1'b1;
    rd = $urandom(32'h01ca_ad50);
    terminal_addr_in = $urandom_range(10, 30);
    tagData = $urandom;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rdChk("cfg", `CFG_OFS, 0);
    rdChk("mask", `MASK_OFS, 0);
    rdChk("stat", `STAT_OFS, 0);
    apb(1'b0, 16'h0010, 0);
    cmp("slverr", 1, err);
    // Terminal: receive, busy transmit, rejected receive, rejected transmit
    for (k = 0; k < 4; k++) begin
      f = $urandom;
      sa = (k == 3) ? 5'h1F : 5'($urandom_range(1, 30));
      wc = $urandom_range(1, 4);
      cmd = {terminal_addr_in, k[0], sa, wc};
      apb(1'b1, `CFG_OFS, {24'h0, f, 1'b0, k != 1, 1'b0, 1'b1});
      apb(1'b1, `MASK_OFS, 32'h1);
      apb(1'b1, ram(`SP_A), 12'hFFC);
      apb(1'b1, ram(`LUT_A + {k[0], sa}), 12'h2FE);
      cmd_reject_n <= !k[1];
      i0 = irqs;
      h0 = hits;
      bm.sendWord(cmd, 1'b1);
      for (j = 0; j < wc && !k[0]; j++) begin
        dat[j] = $urandom;
        bm.sendWord(dat[j], 1'b0);
      end
      waitIdle();
      w = bm.txq.pop_front();
      cmp("status", {2'b11, status(k[1], k == 1)}, w);
      cmp("extra words", 0, bm.txq.size());
      cmp("match pulses", 1, hits - h0);
      cmp("field", (k == 3) ? wc : sa, cmd_field_out);
      cmp("mode latch", k == 3, mode_cmd_latch);
      cmp("bcast", 0, bcast_received);
      if (k == 0)
        cmp("irq pulses", 1, irqs - i0);
      rdChk("block status", ram(12'hFFC), `BS_DONE | (k[1] ? `BS_REJECT : 16'h0));
      rdChk("time tag", ram(12'hFFD), `TAG_NONE);
      rdChk("command", ram(12'hFFE), cmd);
      rdChk("stack ptr", ram(`SP_A), 12'hF00);
      for (j = 0; j < wc && !k[0]; j++)
        rdChk("data", ram({4'h2, 8'hFE + j[7:0]}), dat[j]);
    end
    // Controller: one message on bus A, then the list ends
    cmd = {5'h09, 1'b0, 5'h02, 5'h01};
    dat[0] = $urandom;
    apb(1'b1, `CFG_OFS, 0);
    apb(1'b1, `MASK_OFS, 32'h5);
    apb(1'b1, ram(`SP_A), 12'h020);
    apb(1'b1, ram(`CNT_A), 16'h00FE);
    apb(1'b1, ram(12'h023), 12'h300);
    apb(1'b1, ram(12'h300), 16'h0080);
    apb(1'b1, ram(12'h301), cmd);
    apb(1'b1, ram(12'h302), dat[0]);
    i0 = irqs;
    apb(1'b1, `START_OFS, 1);
    while (bm.txq.size() < 2) @(posedge clk);
    bm.sendWord({5'h09, 11'h0}, 1'b1);
    waitIdle();
    cmp("bc command", {2'b11, cmd}, bm.txq.pop_front());
    cmp("bc data", {2'b10, dat[0]}, bm.txq.pop_front());
    cmp("bc irq", 1, irqs - i0);
    rdChk("bc status", ram(12'h020), `BS_DONE);
    rdChk("bc tag", ram(12'h021), `TAG_NONE);
    rdChk("bc stack ptr", ram(`SP_A), 12'h024);
    rdChk("bc count", ram(`CNT_A), 16'h00FF);
    repeat (2000) @(posedge clk);
    cmp("list end", 0, bm.txq.size());
    test_done();
  end
endmodule
